/* shared/blrj_cfg.svh */
/*
 Constants for the branch loop / return jump control block.
 Assumes a 40 MHz clock and an APB register port.
*/
`ifndef BLRJ_CFG_SVH
`define BLRJ_CFG_SVH
`define BLRJ_OFF_CTRL 12'h000
`define BLRJ_OFF_TGT 12'h004
`define BLRJ_OFF_CNT 12'h008
`define BLRJ_OFF_PADDR 12'h00C
`define BLRJ_OFF_STAT 12'h010
`define BLRJ_OFF_BASE 12'h014
`define BLRJ_OFF_RET 12'h018
`define BLRJ_OFF_MEM 12'h01C
`define BLRJ_OFF_INSTR 12'h020
`define BLRJ_CTRL_LOOP 0
`define BLRJ_CTRL_JUMP 1
`define BLRJ_CTRL_RJ 2
`define BLRJ_CTRL_TEST 3
`define BLRJ_ST_BUSY 0
`define BLRJ_ST_INSTK 1
`define BLRJ_ST_OPVALID 2
`define BLRJ_OP_RJ 2'h1
`define BLRJ_RET_PAT 12'h100
`define BLRJ_TAG_RJ 6'h28
`define BLRJ_TAG_RNI 6'h08
`define BLRJ_MAX_BACK 3'h7
`endif

/* shared/blrj_pkg.sv */
/*
 Types for the branch loop / return jump control block.
 Assumes blrj_cfg.svh is included where the constants are needed.
*/
package blrj_pkg;
   typedef enum logic [3:0] {
      BLRJ_IDLE = 4'h0,
      BLRJ_U2 = 4'h1,
      BLRJ_K2R = 4'h2,
      BLRJ_P1S = 4'h3,
      BLRJ_SMEM = 4'h4,
      BLRJ_R2P = 4'h5,
      BLRJ_P2M0 = 4'h6,
      BLRJ_M1A = 4'h7,
      BLRJ_ADV = 4'h8,
      BLRJ_VOID = 4'h9,
      BLRJ_P2M0B = 4'hA,
      BLRJ_M1B = 4'hB
   } blrj_state_t;
endpackage

/* rtl/blrj_loop_test.sv */
/*
 Combinational loop test: in-stack decision from offset, loop count, depth.
 Assumes counts are true (not complemented) values.
*/
`timescale 1ns/1ps
`include "blrj_cfg.svh"
module blrj_loop_test
   import blrj_pkg::*;
#(
   parameter int CW = 3
) (
   input wire logic signed [CW:0] offset,
   input wire logic [CW-1:0] loop_cnt,
   input wire logic [CW-1:0] depth,
   output logic in_stack,
   output logic [CW:0] l_minus_t
);
   logic signed [CW+1:0] diff;
   logic signed [CW+2:0] d_minus;
   logic fwd;
   logic backward_loop_term;
   logic no_overflow;
   always_comb begin
      diff = $signed({2'b00, loop_cnt}) - (CW+2)'(offset);
      d_minus = $signed({3'b000, depth}) - (CW+3)'(diff);
      fwd = (offset >= 0) && (diff >= 0);
      no_overflow = (diff <= $signed({3'b000, `BLRJ_MAX_BACK}));
      backward_loop_term = (d_minus >= 0);
      in_stack = fwd || ((offset < 0) && backward_loop_term && no_overflow);
      l_minus_t = diff[CW:0];
   end
endmodule

/* rtl/blrj_ctrl.sv */
/*
 Branch loop, jump and return-jump sequencing with an APB register port.
 Assumes an APB master on CLK; address issue unit accepts each pulse.
*/
// The register offsets and the APB slave port are this design's own decisions.
// Overview of operation
// - Loop: target to program address, parcel counter zero, loop count becomes L minus T.
// - Jump: target to program address, fetch request, parcel counter zero, stack voided.
// - In-stack when forward or backward condition; forward needs nonnegative L minus T.
// - Backward: with L minus T at most 7, nonnegative depth difference qualifies.
// - Extra term blocks backward loop on difference overflow, when L minus T exceeds 7.
// - Return jump: instruction to second issue register, address to target, opcode 01.
// - Address to hold register, address plus one stored; word 0400, return, zeros written.
// - Jump address to program address, staged, base added, sent with tag 50.
// - Program address advanced to jump plus one, then stack voided.
// - Advanced address staged, base added, sent with tag 10 as fetch.
// - Loop and depth registers hold ones' complement of their counts.
`timescale 1ns/1ps
`include "blrj_cfg.svh"
module blrj_ctrl
   import blrj_pkg::*;
#(
   parameter int AW = 18,
   parameter int CW = 3
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   output logic [AW-1:0] ADDR_OUT,
   output logic [5:0] TAG_OUT,
   output logic ADDR_VALID,
   output logic [59:0] STORE_WORD,
   output logic [AW-1:0] STORE_ADDR,
   output logic STORE_VALID,
   output logic [1:0] SB_OP,
   output logic SB_VALID
);
   blrj_state_t state_reg;
   logic [AW-1:0] target_reg;
   logic [AW-1:0] paddr_reg;
   logic [AW-1:0] hold_reg;
   logic [AW-1:0] store_reg;
   logic [AW-1:0] base_reg;
   logic [AW-1:0] stage_reg;
   logic [31:0] instr_reg;
   logic [31:0] issue2_reg;
   logic [1:0] parcel_counter_reg;
   logic [CW-1:0] loop_cmp_reg;
   logic [CW-1:0] depth_cmp_reg;
   logic signed [CW:0] offset_reg;
   logic incr_en_reg;
   logic in_stack_reg;
   logic in_stack;
   logic [CW:0] l_minus_t;
   logic wr_acc;
   logic rd_acc;
   logic start_loop;
   logic start_jump;
   logic start_rj;
   logic do_test;
   logic busy;
   logic wr_ctrl;
   logic wr_tgt;
   logic wr_cnt;
   logic wr_paddr;
   logic wr_base;
   logic wr_instr;
   logic [1:0] cnt_parcel;
   logic [CW-1:0] cnt_loop;
   logic [CW-1:0] cnt_depth;
   logic signed [CW:0] cnt_offset;
   logic [31:0] cnt_word;
   logic [31:0] stat_word;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      hit = (a == off);
   endfunction

   assign wr_acc = PSEL && PENABLE && PWRITE;
   assign rd_acc = PSEL && !PENABLE && !PWRITE;
   assign busy = (state_reg != BLRJ_IDLE);

   // One strobe per register, taken at the access edge
   assign wr_ctrl = wr_acc && hit(PADDR, `BLRJ_OFF_CTRL);
   assign wr_tgt = wr_acc && hit(PADDR, `BLRJ_OFF_TGT);
   assign wr_cnt = wr_acc && hit(PADDR, `BLRJ_OFF_CNT);
   assign wr_paddr = wr_acc && hit(PADDR, `BLRJ_OFF_PADDR);
   assign wr_base = wr_acc && hit(PADDR, `BLRJ_OFF_BASE);
   assign wr_instr = wr_acc && hit(PADDR, `BLRJ_OFF_INSTR);

   // Starts are refused while a return jump runs
   assign start_loop = wr_ctrl && PWDATA[`BLRJ_CTRL_LOOP] && !busy;
   assign start_jump = wr_ctrl && PWDATA[`BLRJ_CTRL_JUMP] && !busy;
   assign start_rj = wr_ctrl && PWDATA[`BLRJ_CTRL_RJ] && !busy;
   assign do_test = wr_ctrl && PWDATA[`BLRJ_CTRL_TEST];

   // Count fields; offset has its own nibble so depth can be set freely
   assign cnt_parcel = PWDATA[1:0];
   assign cnt_loop = PWDATA[CW+3:4];
   assign cnt_depth = PWDATA[CW+7:8];
   assign cnt_offset = PWDATA[CW+12:12];
   assign cnt_word = {16'h0000, 4'(offset_reg), 1'b0, depth_cmp_reg, 1'b0, loop_cmp_reg, 2'b00, parcel_counter_reg};
   assign stat_word = {28'h0000000, incr_en_reg, SB_VALID, in_stack_reg, busy};

   // True counts recovered from complemented registers
   blrj_loop_test #(
      .CW(CW)
   ) u_test (
      .offset(offset_reg),
      .loop_cnt(~loop_cmp_reg),
      .depth(~depth_cmp_reg),
      .in_stack(in_stack),
      .l_minus_t(l_minus_t)
   );

   // APB: zero wait states, data on access phase
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA <= 32'h00000000;
      end else begin
         PREADY <= PSEL && !PENABLE;
         PSLVERR <= 1'b0;
         if (rd_acc) begin
            unique case (PADDR)
               `BLRJ_OFF_TGT: PRDATA <= 32'(target_reg);
               `BLRJ_OFF_CNT: PRDATA <= cnt_word;
               `BLRJ_OFF_PADDR: PRDATA <= 32'(paddr_reg);
               `BLRJ_OFF_STAT: PRDATA <= stat_word;
               `BLRJ_OFF_BASE: PRDATA <= 32'(base_reg);
               `BLRJ_OFF_RET: PRDATA <= 32'(store_reg);
               `BLRJ_OFF_INSTR: PRDATA <= issue2_reg;
               default: PRDATA <= 32'h00000000;
            endcase
         end else if (PSEL && !PENABLE) begin
            PRDATA <= 32'h00000000;
         end
      end
   end

   // Software-loaded operands
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         base_reg <= '0;
         instr_reg <= 32'h00000000;
         offset_reg <= '0;
      end else begin
         if (wr_base) base_reg <= PWDATA[AW-1:0];
         if (wr_instr) instr_reg <= PWDATA;
         if (wr_cnt) offset_reg <= cnt_offset;
      end
   end

   // Loop test result latch
   always_ff @(posedge CLK) begin
      if (!RST_N) in_stack_reg <= 1'b0;
      else if (do_test) in_stack_reg <= in_stack;
   end

   // Return jump sequencer
   always_ff @(posedge CLK) begin
      if (!RST_N) state_reg <= BLRJ_IDLE;
      else begin
         unique case (state_reg)
            BLRJ_IDLE: if (start_rj) state_reg <= BLRJ_U2;
            BLRJ_U2: state_reg <= BLRJ_K2R;
            BLRJ_K2R: state_reg <= BLRJ_P1S;
            BLRJ_P1S: state_reg <= BLRJ_SMEM;
            BLRJ_SMEM: state_reg <= BLRJ_R2P;
            BLRJ_R2P: state_reg <= BLRJ_P2M0;
            BLRJ_P2M0: state_reg <= BLRJ_M1A;
            BLRJ_M1A: state_reg <= BLRJ_ADV;
            BLRJ_ADV: state_reg <= BLRJ_VOID;
            BLRJ_VOID: state_reg <= BLRJ_P2M0B;
            BLRJ_P2M0B: state_reg <= BLRJ_M1B;
            BLRJ_M1B: state_reg <= BLRJ_IDLE;
            default: state_reg <= BLRJ_IDLE;
         endcase
      end
   end

   // Program address, target, hold, store
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         paddr_reg <= '0;
         target_reg <= '0;
         hold_reg <= '0;
         store_reg <= '0;
         issue2_reg <= 32'h00000000;
         stage_reg <= '0;
      end else begin
         if (!busy && wr_tgt) target_reg <= PWDATA[AW-1:0];
         if (!busy && wr_paddr) paddr_reg <= PWDATA[AW-1:0];
         if (start_loop || start_jump) paddr_reg <= target_reg;
         unique case (state_reg)
            BLRJ_U2: begin
               issue2_reg <= instr_reg;
               target_reg <= instr_reg[AW-1:0];
            end
            BLRJ_K2R: hold_reg <= target_reg;
            BLRJ_P1S: store_reg <= AW'(paddr_reg + 1'b1);
            BLRJ_R2P: paddr_reg <= hold_reg;
            BLRJ_P2M0: stage_reg <= paddr_reg;
            BLRJ_ADV: if (incr_en_reg) paddr_reg <= AW'(paddr_reg + 1'b1);
            BLRJ_P2M0B: stage_reg <= paddr_reg;
            default: ;
         endcase
      end
   end

   // Increment path enable
   always_ff @(posedge CLK) begin
      if (!RST_N) incr_en_reg <= 1'b1;
      else if (state_reg == BLRJ_SMEM) incr_en_reg <= 1'b0;
      else if (state_reg == BLRJ_P2M0) incr_en_reg <= 1'b1;
      else if (state_reg == BLRJ_ADV) incr_en_reg <= 1'b0;
      else if (state_reg == BLRJ_IDLE) incr_en_reg <= 1'b1;
   end

   // Parcel counter and complemented stack counts
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         parcel_counter_reg <= 2'h0;
         loop_cmp_reg <= '1;
         depth_cmp_reg <= '1;
      end else if (start_loop) begin
         parcel_counter_reg <= 2'h0;
         loop_cmp_reg <= ~l_minus_t[CW-1:0];
      end else if (start_jump || state_reg == BLRJ_VOID) begin
         parcel_counter_reg <= 2'h0;
         loop_cmp_reg <= '1;
         depth_cmp_reg <= '1;
      end else if (!busy && wr_cnt) begin
         parcel_counter_reg <= cnt_parcel;
         loop_cmp_reg <= cnt_loop;
         depth_cmp_reg <= cnt_depth;
      end
   end

   // Scoreboard opcode pulse
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         SB_OP <= 2'h0;
         SB_VALID <= 1'b0;
      end else begin
         SB_VALID <= (state_reg == BLRJ_U2);
         if (state_reg == BLRJ_U2) SB_OP <= `BLRJ_OP_RJ;
      end
   end

   // Return word store pulse
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         STORE_WORD <= 60'h0;
         STORE_ADDR <= '0;
         STORE_VALID <= 1'b0;
      end else begin
         STORE_VALID <= (state_reg == BLRJ_SMEM);
         if (state_reg == BLRJ_SMEM) begin
            STORE_WORD <= {`BLRJ_RET_PAT, 48'(store_reg) << 30};
            STORE_ADDR <= hold_reg;
         end
      end
   end

   // Absolute address issue
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         ADDR_OUT <= '0;
         TAG_OUT <= 6'h00;
         ADDR_VALID <= 1'b0;
      end else begin
         ADDR_VALID <= 1'b0;
         if (start_jump) begin
            ADDR_OUT <= AW'(target_reg + base_reg);
            TAG_OUT <= `BLRJ_TAG_RNI;
            ADDR_VALID <= 1'b1;
         end else if (state_reg == BLRJ_M1A) begin
            ADDR_OUT <= AW'(stage_reg + base_reg);
            TAG_OUT <= `BLRJ_TAG_RJ;
            ADDR_VALID <= 1'b1;
         end else if (state_reg == BLRJ_M1B) begin
            ADDR_OUT <= AW'(stage_reg + base_reg);
            TAG_OUT <= `BLRJ_TAG_RNI;
            ADDR_VALID <= 1'b1;
         end
      end
   end
endmodule

/* tb/blrj_ctrl_monitor.sv */
/*
 Checker for the return-jump and fetch outputs of blrj_ctrl.
 Assumes it is bound to blrj_ctrl and sees only its ports.
*/
`timescale 1ns/1ps
module blrj_ctrl_monitor
#(
   parameter int AW = 18
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic [AW-1:0] ADDR_OUT,
   input wire logic [5:0] TAG_OUT,
   input wire logic ADDR_VALID,
   input wire logic [59:0] STORE_WORD,
   input wire logic STORE_VALID,
   input wire logic [1:0] SB_OP,
   input wire logic SB_VALID
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   sequence s_abs;
      ADDR_VALID && TAG_OUT == 6'h28;
   endsequence
   sequence s_rni;
      ADDR_VALID && TAG_OUT == 6'h08;
   endsequence
   AST_SB_OP: assert property (SB_VALID |-> SB_OP == 2'h1) else $error("bad scoreboard op");
   AST_SB_STORE: assert property (SB_VALID |-> ##3 STORE_VALID) else $error("store not on time");
   AST_PAT: assert property (STORE_VALID |-> STORE_WORD[59:48] == 12'h100 && STORE_WORD[29:0] == 30'h0)
      else $error("bad return word");
   AST_ABS: assert property (STORE_VALID |-> ##3 s_abs) else $error("jump address not sent");
   AST_RNI: assert property (s_abs |-> ##4 s_rni) else $error("fetch not sent");
   AST_PLUS1: assert property (s_abs ##4 s_rni |-> ADDR_OUT == $past(ADDR_OUT, 4) + 1'b1)
      else $error("fetch address not plus one");
   AST_TAGS: assert property (ADDR_VALID |-> TAG_OUT inside {6'h28, 6'h08}) else $error("bad tag");
   AST_ONE_RJ: assert property (SB_VALID |=> !SB_VALID [*8]) else $error("overlapping return jump");
endmodule
bind blrj_ctrl blrj_ctrl_monitor #(.AW(AW)) blrj_ctrl_monitor_inst (.CLK(CLK), .RST_N(RST_N),
   .ADDR_OUT(ADDR_OUT), .TAG_OUT(TAG_OUT), .ADDR_VALID(ADDR_VALID), .STORE_WORD(STORE_WORD),
   .STORE_VALID(STORE_VALID), .SB_OP(SB_OP), .SB_VALID(SB_VALID));

/* tb/blrj_issue_model.sv */
/*
 Address issue unit and scoreboard model: logs every address pulse, keeps the last store and scoreboard op.
 Assumes each pulse is taken at once, with no back pressure.
*/
`timescale 1ns/1ps
module blrj_issue_model
#(
   parameter int AW = 18
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [AW-1:0] addr,
   input wire logic [5:0] tag,
   input wire logic addr_valid,
   input wire logic [59:0] store_word,
   input wire logic [AW-1:0] store_addr,
   input wire logic store_valid,
   input wire logic [1:0] sb_op,
   input wire logic sb_valid,
   output logic [AW+5:0] log_q [4],
   output int n_log,
   output logic [59:0] st_word,
   output logic [AW-1:0] st_addr,
   output logic [1:0] sb_seen
);
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         n_log <= 0;
      end else if (addr_valid) begin
         log_q[n_log % 4] <= {tag, addr};
         n_log <= n_log + 1;
      end
   end
   always_ff @(posedge clk) begin
      if (store_valid) begin
         st_word <= store_word;
         st_addr <= store_addr;
      end
      if (sb_valid) begin
         sb_seen <= sb_op;
      end
   end
endmodule

/* tb/blrj_tb_top.sv */
/*
 Self-checking bench for blrj_ctrl: loop test, loop, jump, return jump.
 Assumes an APB slave that answers with PREADY and the issue model on the far side.
*/
`timescale 1ns/1ps
`include "blrj_cfg.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
   $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module blrj_tb_top;
   logic CLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
   logic [11:0] PADDR = 0;
   logic [31:0] PWDATA = 0, PRDATA, r, w, lf = 32'h65B9;
   logic PREADY, PSLVERR, ADDR_VALID, STORE_VALID, SB_VALID, err;
   logic [17:0] ADDR_OUT, STORE_ADDR, st_addr, b, t, p;
   logic [5:0] TAG_OUT;
   logic [59:0] STORE_WORD, st_word;
   logic [1:0] SB_OP, sb_seen;
   logic [23:0] log_q [4];
   int n_log, n0, i, k, failures = 0, total_checks = 0;
   blrj_ctrl blrj_ctrl_inst (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
      .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .ADDR_OUT(ADDR_OUT), .TAG_OUT(TAG_OUT), .ADDR_VALID(ADDR_VALID), .STORE_WORD(STORE_WORD),
      .STORE_ADDR(STORE_ADDR), .STORE_VALID(STORE_VALID), .SB_OP(SB_OP), .SB_VALID(SB_VALID));
   blrj_issue_model blrj_issue_model_inst (.clk(CLK), .rst_n(RST_N), .addr(ADDR_OUT), .tag(TAG_OUT),
      .addr_valid(ADDR_VALID), .store_word(STORE_WORD), .store_addr(STORE_ADDR), .store_valid(STORE_VALID),
      .sb_op(SB_OP), .sb_valid(SB_VALID), .log_q(log_q), .n_log(n_log), .st_word(st_word),
      .st_addr(st_addr), .sb_seen(sb_seen));
   initial begin
      forever #12.5 CLK = ~CLK;
   end
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Counts are written complemented; signed offset sits in bits 15:12
   function automatic logic exp_in(input logic [31:0] v);
      int tt, df;
      tt = int'($signed(v[15:12]));
      df = (7 - int'(v[6:4])) - tt;
      return tt >= 0 ? df >= 0 : (df <= 7 && (7 - int'(v[10:8])) - df >= 0);
   endfunction
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge CLK);
      PSEL <= 1;
      PENABLE <= 0;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1;
      do @(posedge CLK); while (PREADY !== 1'b1);
      r = PRDATA;
      err = PSLVERR;
      PSEL <= 0;
      PENABLE <= 0;
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge CLK);
      failures++;
      final_report();
   end
   initial begin
      repeat (4) @(posedge CLK);
      RST_N <= 1;
      apb(0, 12'h024, 0);
      `CHK("unmapped", 32'h0, r)
      `CHK("slverr", 1'b0, err)
      for (i = 0; i < 40; i++) begin
         lf = nxt(lf);
         w = i == 0 ? 32'hF070 : i == 1 ? 32'h070 : i == 2 ? 32'h8000 : lf & 32'hF770;
         apb(1, `BLRJ_OFF_CNT, w);
         apb(1, `BLRJ_OFF_CTRL, 32'h8);
         apb(0, `BLRJ_OFF_STAT, 0);
         `CHK("in_stack", exp_in(w), r[1])
      end
      $display("loop test done");
      t = lf[17:0];
      apb(1, `BLRJ_OFF_TGT, {14'h0, t});
      apb(1, `BLRJ_OFF_CNT, 32'h2222);
      apb(1, `BLRJ_OFF_CTRL, 32'h1);
      apb(0, `BLRJ_OFF_PADDR, 0);
      `CHK("loop paddr", t, r[17:0])
      apb(0, `BLRJ_OFF_CNT, 0);
      `CHK("loop cnt", 5'b10000, {r[6:4], r[1:0]})
      $display("loop sequence done");
      for (k = 0; k < 4; k++) begin
         lf = nxt(lf);
         b = lf[17:0];
         lf = nxt(lf);
         t = lf[17:0];
         p = lf[31:14];
         n0 = n_log;
         apb(1, `BLRJ_OFF_BASE, {14'h0, b});
         if (k == 0) begin
            apb(1, `BLRJ_OFF_TGT, {14'h0, t});
            apb(1, `BLRJ_OFF_CTRL, 32'h2);
            apb(0, `BLRJ_OFF_CNT, 0);
            `CHK("jump cnt", 8'b11111100, {r[10:8], r[6:4], r[1:0]})
            `CHK("jump fetch", {6'h08, t + b}, log_q[n0 % 4])
            `CHK("jump count", n0 + 1, n_log)
         end else begin
            apb(1, `BLRJ_OFF_PADDR, {14'h0, p});
            apb(1, `BLRJ_OFF_INSTR, {14'h0, t});
            apb(1, `BLRJ_OFF_CTRL, 32'h4);
            apb(1, `BLRJ_OFF_CTRL, 32'h2);
            r = 1;
            for (i = 0; i < 30 && r[0] === 1'b1; i++) apb(0, `BLRJ_OFF_STAT, 0);
            `CHK("rj count", n0 + 2, n_log)
            `CHK("rj abs", {6'h28, t + b}, log_q[n0 % 4])
            `CHK("rj fetch", {6'h08, t + 18'h1 + b}, log_q[(n0 + 1) % 4])
            `CHK("rj store", {12'h100, p + 18'h1, 30'h0}, st_word)
            `CHK("rj store addr", t, st_addr)
            `CHK("rj op", 2'h1, sb_seen)
            apb(0, `BLRJ_OFF_PADDR, 0);
            `CHK("rj paddr", t + 18'h1, r[17:0])
            apb(0, `BLRJ_OFF_CNT, 0);
            `CHK("rj cnt", 8'b11111100, {r[10:8], r[6:4], r[1:0]})
         end
      end
      $display("jump and return jump done");
      final_report();
   end
endmodule
